// >>> svr_pkg.sv
package svr_pkg;

   // clock and counter sizing
   localparam int CLK_PERIOD_NS = 10;
   localparam int CNT_W         = 40;

   // converts a time in milliseconds into clock cycles, never below one
   function automatic longint msToCycles(input longint ms);
      longint cyc;
      cyc = (ms * 1_000_000) / CLK_PERIOD_NS;
      return (cyc < 1) ? 1 : cyc;
   endfunction

   // documented times in their own unit
   localparam longint RESET_STRETCH_MS = 50;      // reset hold after recovery
   localparam longint WD_SHORT_MS      = 100;     // internal oscillator, short period
   localparam longint WD_LONG_MS       = 1600;    // internal oscillator, long period
   localparam longint WD_CAP_MS        = 100_000; // 0.01 uF timing capacitor

   // derived cycle counts
   localparam logic [CNT_W-1:0] RESET_STRETCH_CYC = CNT_W'(msToCycles(RESET_STRETCH_MS));
   localparam logic [CNT_W-1:0] WD_SHORT_CYC      = CNT_W'(msToCycles(WD_SHORT_MS));
   localparam logic [CNT_W-1:0] WD_LONG_CYC       = CNT_W'(msToCycles(WD_LONG_MS));
   localparam logic [CNT_W-1:0] WD_CAP_CYC        = CNT_W'(msToCycles(WD_CAP_MS));
   localparam logic [CNT_W-1:0] CNT_ZERO          = '0;

   // pin inputs, all asynchronous to clk; comparators give high when above threshold
   typedef struct packed {
      logic watchdogClockSelect;   // high: internal oscillator, low: capacitor
      logic oscillatorTimingInput; // internal mode: high picks the long period
      logic watchdogKickInput;     // toggled by the processor
      logic watchdogKickFloating;  // high while the kick pin is left open
      logic lowLineSense;          // high while the low-line sense is above 1.3 V
      logic powerFailSense;        // high while the power-fail sense is above 1.3 V
      logic mainAboveBackup;       // high while main supply exceeds backup supply
      logic backupNearMain;        // high while backup is within 50 mV of main
      logic chipEnableInN;         // incoming chip enable, active low
   } svr_pins_t;

   localparam svr_pins_t PINS_RESET = '{
      watchdogClockSelect:   1'b1,
      oscillatorTimingInput: 1'b1,
      watchdogKickInput:     1'b0,
      watchdogKickFloating:  1'b1,
      lowLineSense:          1'b0,
      powerFailSense:        1'b0,
      mainAboveBackup:       1'b1,
      backupNearMain:        1'b0,
      chipEnableInN:         1'b1
   };

endpackage

// >>> svr_supervisor.sv
// What this block does
// R1 - clock select low picks capacitor timeout
// R2 - capacitor mode timeout is 100 seconds
// R3 - internal oscillator gives 100 ms or 1.6 s
// R4 - backup nearing main supply pulses reset
// R5 - reset while low line, then 50 ms
// R6 - processor toggles kick within each period
// R7 - missed kick within period pulses reset
// R8 - floating kick input disables the watchdog
// R9 - power-fail flag low below threshold
// R10 - chip select follows input, forced high low-line
// R11 - backup-active low while main exceeds backup
// R12 - backup mode ignores kick and oscillator inputs
// R13 - backup mode: reset, flag low, select high
// R14 - every kick edge restarts the timeout count
module svr_supervisor #(
   parameter logic [svr_pkg::CNT_W-1:0] RESET_STRETCH_CYC = svr_pkg::RESET_STRETCH_CYC,
   parameter logic [svr_pkg::CNT_W-1:0] WD_SHORT_CYC      = svr_pkg::WD_SHORT_CYC,
   parameter logic [svr_pkg::CNT_W-1:0] WD_LONG_CYC       = svr_pkg::WD_LONG_CYC,
   parameter logic [svr_pkg::CNT_W-1:0] WD_CAP_CYC        = svr_pkg::WD_CAP_CYC
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire svr_pkg::svr_pins_t pinsIn,
   output logic                    systemResetN,
   output logic                    powerFailWarningFlagN,
   output logic                    gatedChipSelectN,
   output logic                    backupActiveOutput,
   output logic                    watchdogTimeoutPulse
);

   // synchroniser and edge state
   svr_pkg::svr_pins_t syncA_reg, syncB_reg;
   logic               kickPrev_reg, kickPrev_next;
   logic               nearPrev_reg, nearPrev_next;

   // watchdog and reset stretch state
   logic [svr_pkg::CNT_W-1:0] wdCount_reg, wdCount_next;
   logic [svr_pkg::CNT_W-1:0] holdCount_reg, holdCount_next;
   logic                      wdFire_reg, wdFire_next;

   // output state
   logic systemResetN_reg, systemResetN_next;
   logic pfFlag_reg, pfFlag_next;
   logic csOut_reg, csOut_next;
   logic battOn_reg, battOn_next;

   // decoded conditions
   logic                      backupMode;
   logic                      kickEdge;
   logic                      wdEnabled;
   logic [svr_pkg::CNT_W-1:0] wdLimit;
   logic                      resetCause;

   // two-flop synchroniser; only syncB is read by logic
   always_ff @(posedge clk) begin
      if (rst) begin
         syncA_reg <= svr_pkg::PINS_RESET;
         syncB_reg <= svr_pkg::PINS_RESET;
      end else begin
         syncA_reg <= pinsIn;
         syncB_reg <= syncA_reg;
      end
   end

   // condition decode
   always_comb begin
      backupMode = !syncB_reg.mainAboveBackup;
      kickEdge   = syncB_reg.watchdogKickInput != kickPrev_reg;              // [R14]
      wdEnabled  = !syncB_reg.watchdogKickFloating && !backupMode;          // [R8] [R12]
      if (!syncB_reg.watchdogClockSelect) begin
         wdLimit = WD_CAP_CYC;                                              // [R1] [R2]
      end else if (syncB_reg.oscillatorTimingInput) begin
         wdLimit = WD_LONG_CYC;                                             // [R3]
      end else begin
         wdLimit = WD_SHORT_CYC;                                            // [R3]
      end
      resetCause = !syncB_reg.lowLineSense || backupMode || wdFire_reg      // [R5] [R7] [R13]
                   || (syncB_reg.backupNearMain && !nearPrev_reg);          // [R4]
   end

   // watchdog next state
   always_comb begin
      kickPrev_next = syncB_reg.watchdogKickInput;
      nearPrev_next = syncB_reg.backupNearMain;
      wdCount_next  = wdCount_reg;
      wdFire_next   = 1'b0;
      if (!wdEnabled || !systemResetN_reg || kickEdge) begin
         wdCount_next = svr_pkg::CNT_ZERO;                                  // [R12] [R14]
      end else if (wdCount_reg >= wdLimit - 1'b1) begin
         wdCount_next = svr_pkg::CNT_ZERO;
         wdFire_next  = 1'b1;                                               // [R7]
      end else begin
         wdCount_next = wdCount_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         kickPrev_reg <= 1'b0;
         nearPrev_reg <= 1'b1;
         wdCount_reg  <= svr_pkg::CNT_ZERO;
         wdFire_reg   <= 1'b0;
      end else begin
         kickPrev_reg <= kickPrev_next;
         nearPrev_reg <= nearPrev_next;
         wdCount_reg  <= wdCount_next;
         wdFire_reg   <= wdFire_next;
      end
   end

   // reset stretch and outputs next state
   always_comb begin
      holdCount_next = holdCount_reg;
      if (resetCause) begin
         holdCount_next = RESET_STRETCH_CYC;                                // [R5]
      end else if (holdCount_reg != svr_pkg::CNT_ZERO) begin
         holdCount_next = holdCount_reg - 1'b1;
      end
      systemResetN_next = !resetCause && ((holdCount_reg >> 1) == svr_pkg::CNT_ZERO); // [R5]
      pfFlag_next       = syncB_reg.powerFailSense && !backupMode;          // [R9] [R13]
      csOut_next        = (syncB_reg.lowLineSense && !backupMode) ?
                          syncB_reg.chipEnableInN : 1'b1;                   // [R10] [R13]
      battOn_next       = backupMode;                                       // [R11]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         holdCount_reg    <= RESET_STRETCH_CYC;
         systemResetN_reg <= 1'b0;
         pfFlag_reg       <= 1'b0;
         csOut_reg        <= 1'b1;
         battOn_reg       <= 1'b0;
      end else begin
         holdCount_reg    <= holdCount_next;
         systemResetN_reg <= systemResetN_next;
         pfFlag_reg       <= pfFlag_next;
         csOut_reg        <= csOut_next;
         battOn_reg       <= battOn_next;
      end
   end

   // outputs straight from flops
   assign systemResetN          = systemResetN_reg;
   assign powerFailWarningFlagN = pfFlag_reg;
   assign gatedChipSelectN      = csOut_reg;
   assign backupActiveOutput    = battOn_reg;
   assign watchdogTimeoutPulse  = wdFire_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // checks
   // low line holds reset
   AST_LOWLINE_RESET: assert property (!syncB_reg.lowLineSense |=> !systemResetN) // [R5]
      else $error("reset not asserted during low line");

   // reset outlasts the low line
   AST_STRETCH: assert property ($rose(syncB_reg.lowLineSense) && !backupMode |=> !systemResetN [*3]) // [R5]
      else $error("reset released too early after low line");

   // stretch count above one keeps reset low
   AST_RESET_HOLD: assert property ((holdCount_reg >> 1) != svr_pkg::CNT_ZERO |=> !systemResetN) // [R5]
      else $error("reset released before stretch ran out");

   // expiry at the selected limit
   AST_WD_FIRE: assert property (wdEnabled && systemResetN_reg && !kickEdge // [R7]
                                 && wdCount_reg == wdLimit - 1'b1 |=> wdFire_reg ##1 !systemResetN)
      else $error("missed kick did not reset");

   // short internal period
   AST_WD_SHORT: assert property (wdEnabled && systemResetN_reg && !kickEdge // [R3]
                                  && syncB_reg.watchdogClockSelect && !syncB_reg.oscillatorTimingInput
                                  && wdCount_reg == WD_SHORT_CYC - 1'b1 |=> wdFire_reg)
      else $error("short watchdog period not honoured");

   // long internal period
   AST_WD_LONG: assert property (wdEnabled && systemResetN_reg && !kickEdge // [R3]
                                 && syncB_reg.watchdogClockSelect && syncB_reg.oscillatorTimingInput
                                 && wdCount_reg == WD_LONG_CYC - 1'b1 |=> wdFire_reg)
      else $error("long watchdog period not honoured");

   // capacitor period when the select is low
   AST_WD_CAP: assert property (wdEnabled && systemResetN_reg && !kickEdge // [R1] [R2]
                                && !syncB_reg.watchdogClockSelect
                                && wdCount_reg == WD_CAP_CYC - 1'b1 |=> wdFire_reg)
      else $error("capacitor watchdog period not honoured");

   // timeout is a single-cycle pulse
   AST_FIRE_ONCE: assert property (wdFire_reg |=> !wdFire_reg) // [R7]
      else $error("watchdog pulse longer than one cycle");

   // no counting while reset is out
   AST_QUIET_IN_RESET: assert property (!systemResetN_reg // [R7]
                                        |=> !wdFire_reg && wdCount_reg == svr_pkg::CNT_ZERO)
      else $error("watchdog ran during reset");

   // each kick edge clears the count
   AST_KICK_RESTART: assert property (kickEdge |=> wdCount_reg == svr_pkg::CNT_ZERO) // [R14]
      else $error("kick edge did not restart count");

   // open kick pin never fires
   AST_FLOAT_OFF: assert property (syncB_reg.watchdogKickFloating |=> !wdFire_reg) // [R8]
      else $error("watchdog fired while disabled");

   // backup mode output levels
   AST_BACKUP: assert property (backupMode |=> !systemResetN && !powerFailWarningFlagN // [R13]
                                && gatedChipSelectN && backupActiveOutput && wdCount_reg == svr_pkg::CNT_ZERO)
      else $error("backup mode outputs wrong");

   // backup mode never fires the watchdog
   AST_BACKUP_NO_FIRE: assert property (backupMode |=> !wdFire_reg) // [R12]
      else $error("watchdog fired in backup mode");

   // backup-active low on main supply
   AST_MAIN_UP: assert property (syncB_reg.mainAboveBackup |=> !backupActiveOutput) // [R11]
      else $error("backup-active high on main supply");

   // warning flag tracks the comparator
   AST_PF_FLAG: assert property (!backupMode |=> powerFailWarningFlagN == $past(syncB_reg.powerFailSense)) // [R9]
      else $error("power-fail flag mismatch");

   // chip select gated high on low line
   AST_CS_GATE: assert property (!syncB_reg.lowLineSense |=> gatedChipSelectN) // [R10]
      else $error("chip select not gated high");

   // chip select follows the input otherwise
   AST_CS_FOLLOW: assert property (syncB_reg.lowLineSense && !backupMode // [R10]
                                   |=> gatedChipSelectN == $past(syncB_reg.chipEnableInN))
      else $error("chip select not following input");

   // backup nearing main pulses reset
   AST_NEAR_RESET: assert property ($rose(syncB_reg.backupNearMain) |=> !systemResetN) // [R4]
      else $error("backup near main gave no reset");

endmodule

// >>> svr_cpu_model.sv
module svr_cpu_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       kickEnable,
   input  wire logic [7:0] kickGap,
   output logic            kick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] gapCnt_reg, gapCnt_next;
   logic       kick_reg,   kick_next;
   // toggle the kick line once every kickGap+1 cycles while enabled
   always_comb begin
      gapCnt_next = gapCnt_reg + 8'h01;
      kick_next   = kick_reg;
      if (!kickEnable) begin
         gapCnt_next = 8'h00;
      end else if (gapCnt_reg >= kickGap) begin
         gapCnt_next = 8'h00;
         kick_next   = !kick_reg;
      end
   end
   // registers only
   always_ff @(posedge clk) begin
      gapCnt_reg <= rst ? 8'h00 : gapCnt_next;
      kick_reg   <= rst ? 1'b0 : kick_next;
   end
   assign kick = kick_reg;
endmodule

// >>> test_supervisor_watchdog_reset.sv
module test_supervisor_watchdog_reset;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic ll, pf, ce, main, flag, cs, bk;} svr_row_t;
   localparam int       STRETCH  = 20;
   localparam int       LIM [3]  = '{40, 60, 80};
   localparam svr_row_t ROWS [5] = '{7'h6c, 7'h7e, 7'h48, 7'h63, 7'h2e};
   logic               clk      = 1'b0;
   logic               rst      = 1'b1;
   logic               kickEn   = 1'b0;
   logic               kick;
   logic               resetN, flagN, csN, bkOn, wdPulse;
   svr_pkg::svr_pins_t drv      = svr_pkg::PINS_RESET;
   svr_pkg::svr_pins_t pins;
   int                 error_cnt = 0;
   int                 n_checks  = 0;
   int                 n;
   // clock and kick merge
   always #5 clk = !clk;
   always_comb begin
      pins = drv;
      pins.watchdogKickInput = kick;
   end
   svr_supervisor #(.RESET_STRETCH_CYC(40'(STRETCH)), .WD_SHORT_CYC(40'(LIM[0])),
      .WD_LONG_CYC(40'(LIM[1])), .WD_CAP_CYC(40'(LIM[2]))) svr_supervisor_i (.clk(clk), .rst(rst),
      .pinsIn(pins), .systemResetN(resetN), .powerFailWarningFlagN(flagN), .gatedChipSelectN(csN),
      .backupActiveOutput(bkOn), .watchdogTimeoutPulse(wdPulse));
   svr_cpu_model svr_cpu_model_i (.clk(clk), .rst(rst), .kickEnable(kickEn), .kickGap(8'h19), .kick(kick));
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check1(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // bounded wait for a level, cycle count returned
   task automatic wait_for(ref logic sig, input logic lvl, input int max, output int k);
      k = 0;
      while (sig !== lvl && k < max) begin
         tick(1);
         k++;
      end
      check1(sig, lvl, "bounded wait");
      if (sig !== lvl) final_report();
   endtask
   task automatic quiet(input int k);
      logic seen = 1'b0;
      repeat (k) begin
         tick(1);
         if (wdPulse !== 1'b0) seen = 1'b1;
      end
      check1(seen, 1'b0, "watchdog pulse seen");
   endtask
   // low-line dip then wait for reset release
   task automatic restart();
      drv.lowLineSense = 1'b0;
      tick(6);
      drv.lowLineSense = 1'b1;
      wait_for(resetN, 1'b1, 200, n);
   endtask
   initial begin
      tick(16);
      check1(resetN, 1'b0, "reset during rst");
      check1(wdPulse, 1'b0, "pulse during rst");
      rst = 1'b0;
      // level table: flag, chip select, backup-active
      foreach (ROWS[i]) begin
         {drv.lowLineSense, drv.powerFailSense, drv.chipEnableInN, drv.mainAboveBackup} = ROWS[i][6:3];
         tick(6);
         check1(flagN, ROWS[i].flag, "power-fail flag");
         check1(csN, ROWS[i].cs, "chip select");
         check1(bkOn, ROWS[i].bk, "backup active");
      end
      drv.lowLineSense = 1'b1;
      wait_for(resetN, 1'b1, 200, n);
      drv.lowLineSense = 1'b0;
      wait_for(resetN, 1'b0, 6, n);
      drv.lowLineSense = 1'b1;
      tick(6);
      wait_for(resetN, 1'b1, STRETCH + 10, n);
      check1(n >= STRETCH - 8, 1'b1, "reset stretch too short");
      drv.backupNearMain = 1'b1;
      wait_for(resetN, 1'b0, 6, n);
      wait_for(resetN, 1'b1, STRETCH + 10, n);
      // each watchdog period unkicked
      drv.watchdogKickFloating = 1'b0;
      for (int m = 0; m < 3; m++) begin
         drv.watchdogClockSelect   = (m != 2);
         drv.oscillatorTimingInput = (m == 1);
         restart();
         wait_for(wdPulse, 1'b1, LIM[m] + 10, n);
         check1(n >= LIM[m] - 4, 1'b1, "watchdog fired early");
         wait_for(resetN, 1'b0, 4, n);
      end
      drv.watchdogClockSelect   = 1'b1;
      drv.oscillatorTimingInput = 1'b0;
      kickEn = 1'b1;
      restart();
      quiet(150);
      kickEn = 1'b0;
      wait_for(wdPulse, 1'b1, LIM[0] + 20, n);
      drv.watchdogKickFloating = 1'b1;
      restart();
      quiet(150);
      // second reset in mid-run
      rst = 1'b1;
      tick(2);
      check1(resetN, 1'b0, "reset during second rst");
      check1(csN, 1'b1, "chip select during second rst");
      check1(wdPulse, 1'b0, "pulse during second rst");
      rst = 1'b0;
      wait_for(resetN, 1'b1, 200, n);
      drv.watchdogKickFloating = 1'b0;
      drv.mainAboveBackup = 1'b0;
      quiet(150);
      check1(resetN, 1'b0, "reset in backup");
      final_report();
   end
endmodule
